// >>> src/ffr_pkg.sv
/*
  Shared constants of the FET fault supervision block: register map, field
  layout, threshold tables, timing figures and the supervisor state encoding.
  Assumes a 10 MHz core clock and an 8-bit register port behind the serial engine.
*/
package ffr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FAULT_PRESENT = 8'h03;
  localparam logic [7:0] ADDR_LATCHED_FAULTS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_FIRST = 8'h0A;
  localparam logic [7:0] ADDR_CONTROL_SECOND = 8'h0B;
  localparam logic [7:0] ADDR_LIMIT_FOLDBACK = 8'h0D;
  localparam logic [7:0] ADDR_THRESH_TIMER = 8'h0E;
  localparam logic [7:0] ADDR_REBOOT_DELAY = 8'hA2;
  localparam logic [7:0] ADDR_NV_LIMIT_FOLDBACK = 8'hAD;
  // field positions
  localparam int CODE_LSB = 0;
  localparam int FB_LSB = 4;
  localparam int LOAD_POWER_FOLDBACK_EN_BIT = 6;
  localparam int FBDIS_BIT = 7;
  localparam int DRAIN_HIGH_THRESHOLD_SEL_LSB = 0;
  localparam int FTBD_LSB = 2;
  localparam int COOL_LSB = 4;
  localparam int SHDN_BIT = 0;
  localparam int HOSTON_BIT = 1;
  localparam int RETRY_LSB = 0;
  localparam int FLAG_BIT = 0;
  // threshold figures
  localparam logic [4:0] LIMIT_BASE_MV = 5'h0F;
  localparam logic [4:0] LIMIT_MAX_MV = 5'h1E;
  localparam logic [9:0] RATIO_FULL = 10'h3E8;
  localparam logic [9:0] RATIO_HALF = 10'h1F4;
  localparam logic [9:0] RATIO_FIFTH = 10'h0C8;
  localparam logic [9:0] RATIO_TENTH = 10'h064;
  localparam logic [11:0] KNEE_MV = 12'h384;
  localparam logic [11:0] LOAD_POWER_FOLDBACK_EN_END_MV = 12'h708;
  localparam logic [7:0] DRAIN_TH0_MV = 8'h48;
  localparam logic [7:0] DRAIN_TH1_MV = 8'h66;
  localparam logic [7:0] DRAIN_TH2_MV = 8'h8F;
  localparam logic [7:0] DRAIN_TH3_MV = 8'hCB;
  // timing: one tick per millisecond, delays counted in ticks
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] FAULT_BASE_MS = 12'h100;
  localparam logic [16:0] COOL_BASE_MS = 17'h00200;
  localparam logic [14:0] RETRY_RESET_MS = 15'h4000;
  // retry field codes
  localparam logic [1:0] RETRY_NONE = 2'h0;
  localparam logic [1:0] RETRY_ONE = 2'h1;
  localparam logic [1:0] RETRY_SEVEN = 2'h2;
  localparam logic [1:0] RETRY_FOREVER = 2'h3;
  localparam logic [2:0] RETRY_ONE_CNT = 3'h1;
  localparam logic [2:0] RETRY_SEVEN_CNT = 3'h7;
  // supervisor states
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ON = 5'h02,
    ST_COOL = 5'h04,
    ST_HOLD = 5'h08,
    ST_LOCK = 5'h10
  } ffr_state_t;
endpackage : ffr_pkg

// >>> src/ffr_fold_if.sv
/*
  Carrier between the supervisor and the foldback calculator.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface ffr_fold_if;
  logic [4:0] limitMv;
  logic [1:0] foldbackRatioSel;
  logic loadPowerFoldbackEn;
  logic normalFoldbackDisable;
  logic powerGood;
  logic [11:0] outputMv;
  logic [9:0] ratioPermille;
  logic [14:0] limitUv;
  modport ctrl (output limitMv, foldbackRatioSel, loadPowerFoldbackEn, normalFoldbackDisable,
    powerGood, outputMv, input ratioPermille, limitUv);
  modport calc (input limitMv, foldbackRatioSel, loadPowerFoldbackEn, normalFoldbackDisable,
    powerGood, outputMv, output ratioPermille, limitUv);
endinterface : ffr_fold_if
`default_nettype wire

// >>> src/ffr_sync.sv
/*
  Two-stage synchroniser bank for pin-level inputs.
  Assumes inputs are slow levels; a pulse shorter than one clock can be missed.
*/
`timescale 1ns/1ps
`default_nettype none
module ffr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : gBit
      logic stage1_r;
      // first stage feeds only the second
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          stage1_r <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          stage1_r <= asyncIn[i];
          syncOut[i] <= stage1_r;
        end
      end
    end
  endgenerate
endmodule : ffr_sync
`default_nettype wire

// >>> src/ffr_foldback.sv
/*
  Foldback calculator: turns the limit setting and output voltage into a
  folded ratio and a folded limit in microvolts, both registered.
  Assumes outputMv is an attenuated output sample on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ffr_foldback (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // carrier
  ffr_fold_if.calc fold
);
  logic [9:0] selRatio;
  logic [9:0] ratio;
  logic [11:0] vClip;
  logic [19:0] rampUp;
  logic [19:0] rampDown;
  // selected folded level
  always_comb
  begin
    case (fold.foldbackRatioSel)
      2'h0: selRatio = ffr_pkg::RATIO_TENTH;
      2'h1: selRatio = ffr_pkg::RATIO_FIFTH;
      2'h2: selRatio = ffr_pkg::RATIO_HALF;
      default: selRatio = ffr_pkg::RATIO_FULL;
    endcase
  end
  // profile: flat in startup, voltage ramp once power good
  always_comb
  begin
    vClip = (fold.outputMv > ffr_pkg::LOAD_POWER_FOLDBACK_EN_END_MV) ? ffr_pkg::LOAD_POWER_FOLDBACK_EN_END_MV : fold.outputMv;
    rampUp = 20'((20'(ffr_pkg::RATIO_FULL - selRatio) * 20'(vClip)) / 20'(ffr_pkg::KNEE_MV));
    rampDown = 20'((20'(ffr_pkg::RATIO_HALF) * 20'(vClip - ffr_pkg::KNEE_MV))
      / 20'(ffr_pkg::KNEE_MV));
    if (!fold.powerGood)
      ratio = selRatio;
    else if (vClip < ffr_pkg::KNEE_MV)
      ratio = fold.normalFoldbackDisable ? ffr_pkg::RATIO_FULL
        : 10'(20'(selRatio) + rampUp);
    else if (fold.loadPowerFoldbackEn)
      ratio = 10'(20'(ffr_pkg::RATIO_FULL) - rampDown);
    else
      ratio = ffr_pkg::RATIO_FULL;
  end
  // registered results
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fold.ratioPermille <= ffr_pkg::RATIO_FULL;
      fold.limitUv <= 15'h0000;
    end
    else
    begin
      fold.ratioPermille <= ratio;
      fold.limitUv <= 15'(fold.limitMv) * 15'(ratio); // widen first so the product keeps its top bits
    end
  end
endmodule : ffr_foldback
`default_nettype wire

// >>> src/ffr_fet_fault_retry.sv
/*
  FET fault supervisor: limit and foldback settings, drain-high and gate-low
  detection, fault timer, cooling delay and the auto-retry counter.
  Assumes a register port from the serial engine on core_clk, comparator
  levels arriving asynchronously from the analog front end, and an output
  voltage sample and power-good latch from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ffr_fet_fault_retry #(
  parameter int TICK_CYCLES = ffr_pkg::TICK_CYCLES,
  parameter logic [7:0] NV_LIMIT_DEFAULT = 8'h0F
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // comparator pins
  input wire logic drainAboveRef,
  input wire logic firstFetDriverLow,
  input wire logic secondFetDriverLow,
  input wire logic inCurrentLimit,
  input wire logic parallelMode,
  // on-chip measurements
  input wire logic powerGoodLatched,
  input wire logic [11:0] outputSenseMv,
  // gate command and analog settings
  output logic fetOnCmd,
  output logic [4:0] limitSenseThresholdMv,
  output logic [5:0] fastPulldownThresholdMv,
  output logic [9:0] foldRatioPermille,
  output logic [14:0] foldedLimitUv,
  output logic [1:0] drainHighThresholdSel,
  output logic [7:0] drainHighThresholdMv,
  // status levels
  output logic fetFaultPresent,
  output logic fetFaultLatched,
  output logic delayRunning
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] nvCfg_r;
  logic [7:0] limitFoldbackCfg_r;
  logic [7:0] threshTimerCfg_r;
  logic [7:0] controlFirst_r;
  logic [7:0] controlSecond_r;
  logic nvLoaded_r;
  logic [2:0] pinSync;
  logic [1:0] strapSync;
  logic drainHigh;
  logic gateLow;
  logic fetBad;
  logic [TCW-1:0] tickCnt_r;
  logic tick;
  logic present_r;
  logic latched_r;
  logic [11:0] faultMs_r;
  logic faultDone_r;
  logic [11:0] faultDurMs;
  logic faultExpire;
  logic [16:0] coolMs_r;
  logic [16:0] coolDurMs;
  logic coolExpire;
  logic [14:0] rstMs_r;
  logic rstRunning_r;
  logic [2:0] retryCnt_r;
  logic [2:0] retryCnt_nxt;
  logic [2:0] retryLimit;
  logic [2:0] retryBase;
  logic retryStart;
  logic shutdown;
  logic hostOn;
  logic shutdownEn;
  logic [1:0] retrySel;
  logic [3:0] currentLimitCode;
  logic [4:0] limitMv;
  logic clearLatchWr;
  ffr_pkg::ffr_state_t state_r;
  ffr_pkg::ffr_state_t state_nxt;
  ffr_fold_if foldBus();

  assign hostOn = controlFirst_r[ffr_pkg::HOSTON_BIT];
  assign shutdownEn = controlFirst_r[ffr_pkg::SHDN_BIT];
  assign retrySel = controlSecond_r[ffr_pkg::RETRY_LSB +: 2];
  assign currentLimitCode = limitFoldbackCfg_r[ffr_pkg::CODE_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ffr_sync #(.W(3)) uPinSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn({drainAboveRef, firstFetDriverLow, secondFetDriverLow}),
    .syncOut(pinSync)
  );
  ffr_sync #(.W(2)) uStrapSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn({inCurrentLimit, parallelMode}),
    .syncOut(strapSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // nonvolatile copy, then one load into the live copy after reset release
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      nvCfg_r <= NV_LIMIT_DEFAULT;
      limitFoldbackCfg_r <= 8'h00;
      nvLoaded_r <= 1'b0;
    end
    else
    begin
      nvLoaded_r <= 1'b1;
      if (regWrEn && regAddr == ffr_pkg::ADDR_NV_LIMIT_FOLDBACK)
        nvCfg_r <= regWrData;
      if (!nvLoaded_r)
        limitFoldbackCfg_r <= nvCfg_r;
      else if (regWrEn && regAddr == ffr_pkg::ADDR_LIMIT_FOLDBACK)
        limitFoldbackCfg_r <= regWrData;
    end
  end

  // thresholds, timers and control words
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      threshTimerCfg_r <= 8'h00;
      controlFirst_r <= 8'h00;
      controlSecond_r <= 8'h00;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        ffr_pkg::ADDR_THRESH_TIMER: threshTimerCfg_r <= {1'b0, regWrData[6:0]};
        ffr_pkg::ADDR_CONTROL_FIRST: controlFirst_r <= {6'h00, regWrData[1:0]};
        ffr_pkg::ADDR_CONTROL_SECOND: controlSecond_r <= {6'h00, regWrData[1:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog settings derived from the configuration
  always_comb
  begin
    limitMv = ffr_pkg::LIMIT_BASE_MV + {1'b0, currentLimitCode};
    if (limitMv > ffr_pkg::LIMIT_MAX_MV)
      limitMv = ffr_pkg::LIMIT_MAX_MV;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      limitSenseThresholdMv <= ffr_pkg::LIMIT_BASE_MV;
      fastPulldownThresholdMv <= {ffr_pkg::LIMIT_BASE_MV, 1'b0};
      drainHighThresholdSel <= 2'h0;
      drainHighThresholdMv <= ffr_pkg::DRAIN_TH0_MV;
    end
    else
    begin
      limitSenseThresholdMv <= limitMv;
      fastPulldownThresholdMv <= {limitMv, 1'b0};
      drainHighThresholdSel <= threshTimerCfg_r[ffr_pkg::DRAIN_HIGH_THRESHOLD_SEL_LSB +: 2];
      case (threshTimerCfg_r[ffr_pkg::DRAIN_HIGH_THRESHOLD_SEL_LSB +: 2])
        2'h0: drainHighThresholdMv <= ffr_pkg::DRAIN_TH0_MV;
        2'h1: drainHighThresholdMv <= ffr_pkg::DRAIN_TH1_MV;
        2'h2: drainHighThresholdMv <= ffr_pkg::DRAIN_TH2_MV;
        default: drainHighThresholdMv <= ffr_pkg::DRAIN_TH3_MV;
      endcase
    end
  end

  // foldback calculation
  assign foldBus.limitMv = limitSenseThresholdMv;
  assign foldBus.foldbackRatioSel = limitFoldbackCfg_r[ffr_pkg::FB_LSB +: 2];
  assign foldBus.loadPowerFoldbackEn = limitFoldbackCfg_r[ffr_pkg::LOAD_POWER_FOLDBACK_EN_BIT];
  assign foldBus.normalFoldbackDisable = limitFoldbackCfg_r[ffr_pkg::FBDIS_BIT];
  assign foldBus.powerGood = powerGoodLatched;
  assign foldBus.outputMv = outputSenseMv;
  assign foldRatioPermille = foldBus.ratioPermille;
  assign foldedLimitUv = foldBus.limitUv;

  ffr_foldback uFoldback (
    .core_clk(core_clk),
    .rst(rst),
    .fold(foldBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // FET bad detection
  always_comb
  begin
    drainHigh = pinSync[2];
    if (strapSync[0])
      gateLow = (pinSync[1] & pinSync[0])
        | ((pinSync[1] ^ pinSync[0]) & ~strapSync[1]);
    else
      gateLow = pinSync[1] | pinSync[0];
    fetBad = fetOnCmd & (drainHigh | gateLow);
  end

  // millisecond tick
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tickCnt_r <= '0;
    else if (tickCnt_r == TICK_LAST)
      tickCnt_r <= '0;
    else
      tickCnt_r <= tickCnt_r + TCW'(1);
  end
  assign tick = (tickCnt_r == TICK_LAST);

  // present flag follows the condition while on, drops at shutdown
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      present_r <= 1'b0;
    else
      present_r <= fetBad & ~shutdown;
  end

  // fault timer
  assign faultDurMs = ffr_pkg::FAULT_BASE_MS << threshTimerCfg_r[ffr_pkg::FTBD_LSB +: 2];
  assign faultExpire = present_r & tick & ~faultDone_r & (faultMs_r == faultDurMs - 12'h001);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      faultMs_r <= 12'h000;
      faultDone_r <= 1'b0;
    end
    else if (!present_r)
    begin
      faultMs_r <= 12'h000;
      faultDone_r <= 1'b0;
    end
    else if (faultExpire)
      faultDone_r <= 1'b1;
    else if (tick && !faultDone_r)
      faultMs_r <= faultMs_r + 12'h001;
  end

  // latched fault: expiry wins over a clearing write
  assign clearLatchWr = regWrEn & (regAddr == ffr_pkg::ADDR_LATCHED_FAULTS)
    & ~regWrData[ffr_pkg::FLAG_BIT];
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      latched_r <= 1'b0;
    else if (faultExpire)
      latched_r <= 1'b1;
    else if (clearLatchWr)
      latched_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // retry bookkeeping
  assign retryLimit = (retrySel == ffr_pkg::RETRY_ONE) ? ffr_pkg::RETRY_ONE_CNT
    : ffr_pkg::RETRY_SEVEN_CNT;
  assign retryBase = rstRunning_r ? retryCnt_r : 3'h0;
  assign shutdown = faultExpire & shutdownEn & (state_r == ffr_pkg::ST_ON);

  // supervisor next state
  always_comb
  begin
    state_nxt = state_r;
    retryCnt_nxt = retryCnt_r;
    retryStart = 1'b0;
    case (state_r)
      ffr_pkg::ST_OFF:
        if (hostOn)
          state_nxt = ffr_pkg::ST_ON;
      ffr_pkg::ST_ON:
        if (shutdown)
        begin
          if (retrySel == ffr_pkg::RETRY_NONE)
            state_nxt = ffr_pkg::ST_HOLD;
          else if (retrySel == ffr_pkg::RETRY_FOREVER)
            state_nxt = ffr_pkg::ST_COOL;
          else if (retryBase >= retryLimit)
            state_nxt = ffr_pkg::ST_LOCK;
          else
          begin
            retryCnt_nxt = retryBase + 3'h1;
            state_nxt = ffr_pkg::ST_COOL;
          end
        end
      ffr_pkg::ST_COOL:
        if (coolExpire)
        begin
          state_nxt = ffr_pkg::ST_ON;
          retryStart = (retrySel == ffr_pkg::RETRY_ONE) | (retrySel == ffr_pkg::RETRY_SEVEN);
        end
      ffr_pkg::ST_HOLD:
        if (!latched_r || !shutdownEn)
          state_nxt = ffr_pkg::ST_COOL;
      ffr_pkg::ST_LOCK:
        state_nxt = ffr_pkg::ST_LOCK;
      default:
        state_nxt = ffr_pkg::ST_OFF;
    endcase
    if (!hostOn)
      state_nxt = ffr_pkg::ST_OFF;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= ffr_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  // cooling delay, restarted on entry
  assign coolDurMs = ffr_pkg::COOL_BASE_MS << threshTimerCfg_r[ffr_pkg::COOL_LSB +: 3];
  assign coolExpire = tick & (coolMs_r == coolDurMs - 17'h00001);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      coolMs_r <= 17'h00000;
    else if (state_r != ffr_pkg::ST_COOL)
      coolMs_r <= 17'h00000;
    else if (tick)
      coolMs_r <= coolMs_r + 17'h00001;
  end

  // counter reset timer, started at each finite retry
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rstMs_r <= 15'h0000;
      rstRunning_r <= 1'b0;
      retryCnt_r <= 3'h0;
    end
    else
    begin
      retryCnt_r <= retryCnt_nxt;
      if (retryStart)
      begin
        rstMs_r <= 15'h0000;
        rstRunning_r <= 1'b1;
      end
      else if (rstRunning_r && tick)
      begin
        if (rstMs_r == ffr_pkg::RETRY_RESET_MS - 15'h0001)
        begin
          rstRunning_r <= 1'b0;
          retryCnt_r <= 3'h0;
        end
        else
          rstMs_r <= rstMs_r + 15'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and register reads
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fetOnCmd <= 1'b0;
      delayRunning <= 1'b0;
    end
    else
    begin
      fetOnCmd <= (state_nxt == ffr_pkg::ST_ON);
      delayRunning <= (state_nxt == ffr_pkg::ST_COOL);
    end
  end
  assign fetFaultPresent = present_r;
  assign fetFaultLatched = latched_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (regRdEn)
    begin
      case (regAddr)
        ffr_pkg::ADDR_FAULT_PRESENT: regRdData <= {7'h00, present_r};
        ffr_pkg::ADDR_LATCHED_FAULTS: regRdData <= {7'h00, latched_r};
        ffr_pkg::ADDR_CONTROL_FIRST: regRdData <= controlFirst_r;
        ffr_pkg::ADDR_CONTROL_SECOND: regRdData <= controlSecond_r;
        ffr_pkg::ADDR_LIMIT_FOLDBACK: regRdData <= limitFoldbackCfg_r;
        ffr_pkg::ADDR_THRESH_TIMER: regRdData <= threshTimerCfg_r;
        ffr_pkg::ADDR_REBOOT_DELAY: regRdData <= {7'h00, delayRunning};
        ffr_pkg::ADDR_NV_LIMIT_FOLDBACK: regRdData <= nvCfg_r;
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule : ffr_fet_fault_retry
`default_nettype wire

// >>> dv/ffr_fet_model.sv
/* Pass device model: drain and gate comparators. Assumes the bench sets the fault knobs. */
`timescale 1ns/1ps
`default_nettype none
module ffr_fet_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // gate command and fault knobs
  input wire logic fetOnCmd,
  input wire logic slowRamp,
  input wire logic badDrain,
  input wire logic [1:0] badGate,
  // comparator levels
  output logic drainAboveRef,
  output logic firstFetDriverLow,
  output logic secondFetDriverLow
);
  logic [3:0] rampCnt_r;
  logic gateUp;
  // gate charge time after turn-on
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      rampCnt_r <= 4'h0;
    else if (!fetOnCmd)
      rampCnt_r <= 4'h0;
    else if (rampCnt_r != 4'hF)
      rampCnt_r <= rampCnt_r + 4'h1;
  // slow fets need the whole ramp, prompt ones a single clock
  assign gateUp = slowRamp ? (rampCnt_r == 4'hF) : (rampCnt_r != 4'h0);
  // an off fet shows a low gate and a high drain, a damaged one only the faults its knobs set
  assign drainAboveRef = !gateUp || badDrain;
  assign firstFetDriverLow = !gateUp || badGate[0];
  assign secondFetDriverLow = !gateUp || badGate[1];
endmodule : ffr_fet_model
`default_nettype wire

// >>> dv/ffr_assertions.sv
/* Port assertions for the fault supervisor. Assumes a bind onto its top ports. */
`timescale 1ns/1ps
`default_nettype none
module ffr_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // inputs seen
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic powerGoodLatched,
  // outputs seen
  input wire logic fetOnCmd,
  input wire logic [4:0] limitSenseThresholdMv,
  input wire logic [5:0] fastPulldownThresholdMv,
  input wire logic [9:0] foldRatioPermille,
  input wire logic [1:0] drainHighThresholdSel,
  input wire logic [7:0] drainHighThresholdMv,
  input wire logic fetFaultPresent,
  input wire logic fetFaultLatched,
  input wire logic delayRunning
);
  // single clock domain
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // settings and status relations
  AST_LIMIT_SPAN: assert property (limitSenseThresholdMv inside {[5'h0F:5'h1E]})
    else $error("limit out of span");
  AST_FAST_TWICE: assert property (fastPulldownThresholdMv == {limitSenseThresholdMv, 1'b0})
    else $error("fast threshold not twice limit");
  AST_DRAIN_TABLE: assert property (drainHighThresholdMv == (drainHighThresholdSel[1] ?
    (drainHighThresholdSel[0] ? 8'hCB : 8'h8F) : (drainHighThresholdSel[0] ? 8'h66 : 8'h48)))
    else $error("drain threshold wrong");
  AST_STARTUP_FLAT: assert property (!powerGoodLatched [*3] |->
    foldRatioPermille inside {10'h064, 10'h0C8, 10'h1F4, 10'h3E8})
    else $error("startup ratio not flat");
  AST_PRESENT_CAUSE: assert property ($rose(fetFaultPresent) |-> $past(fetOnCmd))
    else $error("present set while off");
  AST_OFF_CLEARS: assert property (!fetOnCmd |=> !fetFaultPresent)
    else $error("present kept while off");
  AST_DELAY_OFF: assert property ($rose(delayRunning) |-> !fetOnCmd [*8])
    else $error("on during cooling");
  AST_LATCH_HOLDS: assert property ($fell(fetFaultLatched) |->
    $past(regWrEn && regAddr == 8'h04 && !regWrData[0]))
    else $error("latch dropped without clear");
  // main scenarios
  cover property ($rose(fetFaultLatched));
  cover property ($fell(delayRunning) ##1 fetOnCmd);
  cover property ($fell(fetFaultPresent) && fetOnCmd);
endmodule : ffr_assertions
bind ffr_fet_fault_retry ffr_assertions chk_u (.core_clk, .rst, .regAddr, .regWrEn, .regWrData,
  .powerGoodLatched, .fetOnCmd, .limitSenseThresholdMv, .fastPulldownThresholdMv,
  .foldRatioPermille, .drainHighThresholdSel, .drainHighThresholdMv, .fetFaultPresent,
  .fetFaultLatched, .delayRunning);
`default_nettype wire

// >>> dv/tb_top.sv
/* Bench: register rows, threshold loop, fault and retry cases. Assumes 4 clocks per tick. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] a, d, rd; logic pg; logic [11:0] mv; logic [9:0] rt;} ffr_row_t;
  localparam int TK = 4;
  logic core_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, powerGoodLatched = 1'b0;
  logic inCurrentLimit = 1'b0, parallelMode = 1'b0, slowRamp = 1'b0, badDrain = 1'b0;
  logic drainAboveRef, firstFetDriverLow, secondFetDriverLow;
  logic fetOnCmd, fetFaultPresent, fetFaultLatched, delayRunning;
  logic [1:0] badGate = 2'h0, drainHighThresholdSel;
  logic [4:0] limitSenseThresholdMv;
  logic [5:0] fastPulldownThresholdMv;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, drainHighThresholdMv;
  logic [9:0] foldRatioPermille;
  logic [11:0] outputSenseMv = 12'h000;
  logic [14:0] foldedLimitUv;
  logic [7:0] dth [4] = '{8'h48, 8'h66, 8'h8F, 8'hCB};
  logic [4:0] gc [4] = '{5'h0D, 5'h19, 5'h1F, 5'h16};
  int err_total = 0, checks = 0, n;
  ffr_row_t rows [14] = '{'{8'h0E, 8'hFF, 8'h7F, 0, 0, 0}, '{8'h0A, 8'hFC, 8'h00, 0, 0, 0},
    '{8'h0B, 8'hFF, 8'h03, 0, 0, 0}, '{8'h03, 8'hFF, 8'h00, 0, 0, 0},
    '{8'hA2, 8'hFF, 8'h00, 0, 0, 0}, '{8'h55, 8'hFF, 8'h00, 0, 0, 0},
    '{8'hAD, 8'h12, 8'h12, 0, 0, 0}, '{8'h0D, 8'h00, 8'h00, 0, 0, 10'h064},
    '{8'h0D, 8'h10, 8'h10, 0, 0, 10'h0C8}, '{8'h0D, 8'h30, 8'h30, 0, 0, 10'h3E8},
    '{8'h0D, 8'h20, 8'h20, 1, 12'h1C2, 10'h2EE}, '{8'h0D, 8'h40, 8'h40, 1, 12'h546, 10'h2EE},
    '{8'h0D, 8'h80, 8'h80, 1, 0, 10'h3E8}, '{8'h0D, 8'hC0, 8'hC0, 1, 12'h708, 10'h1F4}};
  // design and far-side model
  ffr_fet_fault_retry #(.TICK_CYCLES(TK), .NV_LIMIT_DEFAULT(8'h25)) dut_u (.core_clk, .rst,
    .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .drainAboveRef, .firstFetDriverLow,
    .secondFetDriverLow, .inCurrentLimit, .parallelMode, .powerGoodLatched, .outputSenseMv,
    .fetOnCmd, .limitSenseThresholdMv, .fastPulldownThresholdMv, .foldRatioPermille,
    .foldedLimitUv, .drainHighThresholdSel, .drainHighThresholdMv, .fetFaultPresent,
    .fetFaultLatched, .delayRunning);
  ffr_fet_model fet_u (.core_clk, .rst, .fetOnCmd, .slowRamp, .badDrain, .badGate,
    .drainAboveRef, .firstFetDriverLow, .secondFetDriverLow);
  // 10 MHz clock
  initial
    forever #50 core_clk = ~core_clk;
  ////////////////////////////////////////
  // bus and compare helpers, inputs move 1 ns after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    cyc(1);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    cyc(1);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    cyc(1);
    {regAddr, regRdEn} = {a, 1'b1};
    cyc(1);
    regRdEn = 1'b0;
    chk("rdata", regRdData, e);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wt(input logic lat, v, input int lim);
    for (n = 0; (lat ? fetFaultLatched : fetOnCmd) !== v; n++)
    begin
      if (n >= lim)
      begin
        chk("timeout", 16'h0, 16'h1);
        conclude();
      end
      cyc(1);
    end
  endtask : wt
  // main sequence
  initial
  begin
    cyc(4);
    chk("rstlim", limitSenseThresholdMv, 16'h0F);
    rst = 1'b0;
    rd(8'h0D, 8'h25);
    cyc(2);
    chk("nvlim", limitSenseThresholdMv, 16'h14);
    chk("folded", foldedLimitUv, 16'h2710);
    $display("test reset done");
    foreach (rows[i])
    begin
      {powerGoodLatched, outputSenseMv} = {rows[i].pg, rows[i].mv};
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].rd);
      cyc(3);
      if (rows[i].rt != 10'h000)
        chk("ratio", foldRatioPermille, rows[i].rt);
    end
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h0D, 8'(c));
      wr(8'h0E, 8'(c % 4));
      cyc(2);
      chk("limit", limitSenseThresholdMv, 16'(15 + c));
      chk("fast", fastPulldownThresholdMv, 16'(30 + 2 * c));
      chk("drain", drainHighThresholdMv, dth[c % 4]);
      chk("dsel", drainHighThresholdSel, 16'(c % 4));
    end
    $display("test settings done");
    wr(8'h0E, 8'h00);
    wr(8'h0B, 8'h01);
    wr(8'h0A, 8'h03);
    wt(0, 1, 3000);
    cyc(40);
    foreach (gc[i])
    begin
      {parallelMode, inCurrentLimit, badGate} = gc[i][3:0];
      cyc(6);
      chk("gatelow", fetFaultPresent, gc[i][4]);
    end
    rd(8'h03, 8'h01);
    {parallelMode, badGate} = 3'h0;
    cyc(6);
    chk("cleared", fetFaultPresent, 16'h0);
    repeat (2)
    begin
      badDrain = 1'b1;
      cyc(900);
      badDrain = 1'b0;
      cyc(10);
    end
    chk("nolatch", fetFaultLatched, 16'h0);
    $display("test detect done");
    badDrain = 1'b1;
    wt(1, 1, 1100);
    chk("ftimer", 16'(n >= 256 * TK - 4 && n <= 256 * TK + 12), 16'h1);
    cyc(2);
    chk("shut", {fetOnCmd, fetFaultPresent, delayRunning}, 16'h1);
    wt(0, 1, 2200);
    chk("cool", 16'(n >= 512 * TK - 8 && n <= 512 * TK + 12), 16'h1);
    wt(0, 0, 1200);
    cyc(3000);
    chk("lock", fetOnCmd, 16'h0);
    badDrain = 1'b0;
    wr(8'h0A, 8'h00);
    wr(8'h04, 8'h00);
    $display("test retry done");
    slowRamp = 1'b1;
    wr(8'h0E, 8'h0C);
    wr(8'h0A, 8'h02);
    wt(0, 1, 3000);
    cyc(40);
    badDrain = 1'b1;
    wt(1, 1, 8400);
    chk("ftimer3", 16'(n >= 2048 * TK - 4 && n <= 2048 * TK + 12), 16'h1);
    cyc(10);
    chk("stayon", fetOnCmd, 16'h1);
    badDrain = 1'b0;
    wr(8'h04, 8'h00);
    $display("test noshut done");
    wr(8'h0B, 8'h00);
    wr(8'h0E, 8'h10);
    wr(8'h0A, 8'h03);
    badDrain = 1'b1;
    wt(1, 1, 1100);
    badDrain = 1'b0;
    cyc(5000);
    chk("hold", fetOnCmd, 16'h0);
    wr(8'h04, 8'h00);
    wt(0, 1, 4300);
    chk("restart", 16'(n >= 1024 * TK - 8 && n <= 1024 * TK + 12), 16'h1);
    $display("test noretry done");
    wr(8'h0B, 8'h03);
    wr(8'h0E, 8'h00);
    badDrain = 1'b1;
    repeat (2)
    begin
      wt(0, 0, 1100);
      wt(0, 1, 2200);
      chk("recool", 16'(n >= 512 * TK - 8 && n <= 512 * TK + 12), 16'h1);
    end
    $display("test forever done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
